//--- obwc_checker.sv
// Checker for the boot configuration byte loader.
// Assumes binding to the loader top; watches its ports only.
`timescale 1ns/1ps
module obwc_checker (
  input wire        clock,
  input wire        sys_rst,
  input wire [15:0] flash_addr,
  input wire        flash_rd,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        self_prog_busy,
  input wire        cfg_valid,
  input wire [1:0]  window_open_sel,
  input wire [4:0]  wdt_overflow_exp,
  input wire        wdt_count_enable,
  input wire        lowspeed_osc_run,
  input wire        aux_timer_clk_en
);
  // ==========================================
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence apb_done; psel && penable && pready; endsequence
  sequence keep_wr; apb_done ##0 pwrite && paddr == 12'h004 && !pwdata[0]; endsequence
  sequence stat_rd; apb_done ##0 !pwrite && paddr == 12'h008 && $past(cfg_valid, 2); endsequence
  addr_legal_a: assert property (
    flash_rd |-> flash_addr == 16'h0080 || flash_addr == 16'h1080)
    else $error("flash address off");
  single_read_a: assert property (cfg_valid |-> !flash_rd)
    else $error("flash read after load");
  cfg_hold_a: assert property (
    $past(cfg_valid, 2) |-> $stable(window_open_sel) && $stable(wdt_overflow_exp))
    else $error("decoded fields moved");
  ovf_range_a: assert property (
    $past(cfg_valid, 2) |-> wdt_overflow_exp >= 5'h0A && wdt_overflow_exp <= 5'h11)
    else $error("overflow exponent out of range");
  window_pct_a: assert property (
    stat_rd |-> prdata[10:4] == (7'(window_open_sel) + 7'h1) * 7'h19)
    else $error("window percent wrong");
  run_cause_a: assert property (wdt_count_enable |-> cfg_valid)
    else $error("watchdog runs unloaded");
  busy_count_a: assert property (
    wdt_count_enable && self_prog_busy |=> wdt_count_enable)
    else $error("watchdog stopped while busy");
  aux_osc_a: assert property (aux_timer_clk_en |-> lowspeed_osc_run)
    else $error("aux clock without oscillator");
  osc_keep_a: assert property (keep_wr |-> ##[1:3] lowspeed_osc_run)
    else $error("oscillator not running");
endmodule

//--- obwc_decode.v
// Field decoder for the latched configuration byte.
// Assumes the byte is stable; purely combinational.
`timescale 1ns/1ps
`include "obwc_defs.vh"
module obwc_decode (
  input  wire [7:0] cfg_byte,
  output wire [1:0] window_open_sel,
  output wire [6:0] window_open_pct,
  output wire       wdt_run_at_reset,
  output wire [2:0] wdt_overflow_sel,
  output wire [4:0] wdt_overflow_exp,
  output wire       lowspeed_osc_lock,
  output wire       cfg_illegal
);
  function [6:0] obwc_pct;
    input [1:0] code;
    begin
      case (code)
        2'h0:    obwc_pct = 7'h19;
        2'h1:    obwc_pct = 7'h32;
        2'h2:    obwc_pct = 7'h4B;
        default: obwc_pct = 7'h64;
      endcase
    end
  endfunction
  assign window_open_sel   = cfg_byte[`OBWC_WIN_HI:`OBWC_WIN_LO];
  assign window_open_pct   = obwc_pct(window_open_sel);
  assign wdt_run_at_reset  = cfg_byte[`OBWC_BIT_RUN];
  assign wdt_overflow_sel  = cfg_byte[`OBWC_OVF_HI:`OBWC_OVF_LO];
  assign wdt_overflow_exp  = `OBWC_OVF_BASE_EXP + {2'h0, wdt_overflow_sel};
  assign lowspeed_osc_lock = cfg_byte[`OBWC_BIT_LOCK];
  // Forbidden pairing and nonzero spare bit are flagged, not corrected
  assign cfg_illegal = ((wdt_overflow_sel == 3'h0) && (window_open_sel == 2'h0))
                       || cfg_byte[`OBWC_BIT_SPARE];
endmodule

//--- obwc_defs.vh
// Constants for the boot configuration byte loader.
// Assumes inclusion by bare name from the loader files.
`ifndef OBWC_DEFS_VH
`define OBWC_DEFS_VH
// ==========================================
// Flash locations
`define OBWC_FLASH_AW        16
`define OBWC_ADDR_PRIMARY    16'h0080
`define OBWC_ADDR_SWAP       16'h1080
// ==========================================
// Field positions of the configuration byte
`define OBWC_BIT_SPARE       7
`define OBWC_WIN_HI          6
`define OBWC_WIN_LO          5
`define OBWC_BIT_RUN         4
`define OBWC_OVF_HI          3
`define OBWC_OVF_LO          1
`define OBWC_BIT_LOCK        0
`define OBWC_OVF_BASE_EXP    5'h0A
// ==========================================
// APB register map (byte addresses)
`define OBWC_REG_CFG         12'h080
`define OBWC_REG_CTRL        12'h004
`define OBWC_REG_STAT        12'h008
`define OBWC_CTRL_RESET      8'h00
// ==========================================
// Timing: flash read wait, cycles of clock
`define OBWC_FLASH_WAIT      2'h2
`endif

//--- obwc_flash_model.sv
// Flash array model holding the configuration byte.
// Assumes one-cycle read pulses; data shown for four cycles after each read pulse.
`timescale 1ns/1ps
module obwc_flash_model (
  input  wire        clock,
  input  wire [15:0] flash_addr,
  input  wire        flash_rd,
  input  wire [7:0]  cfg_byte,
  output wire [7:0]  flash_rdata
);
  // ==========================================
  // Read window
  logic [2:0]  cnt = 3'h0;
  logic [15:0] a = 16'h0;
  logic [7:0]  tog = 8'h5A;
  always @(posedge clock) begin
    tog <= ~tog;
    if (flash_rd) begin
      a <= flash_addr;
      cnt <= 3'h4;
    end else if (cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end
  end
  // Both locations carry one byte; idle bus keeps toggling
  assign flash_rdata = (cnt != 3'h0 && (a == 16'h0080 || a == 16'h1080)) ?
                       cfg_byte : tog;
endmodule

//--- obwc_loader.v
// Boot configuration byte loader with watchdog and oscillator controls.
// Assumes a flash read port with fixed latency and an APB master.
//
// What this block does
// - Read one config byte from primary location, or swap location during boot swap.
// - Bits 6..5 select window open at 25, 50, 75 or 100 percent.
// - Bit 4 at 1 starts watchdog counting after reset; at 0 stays stopped until a CTRL write sets bit 1.
// - Bits 3..1 give overflow as two to the (10 plus code) oscillator periods.
// - Bit 0 at 1 keeps oscillator running despite a stop request.
// - Watchdog keeps counting during self-programming.
// - With lock at 0, watchdog count clock is gated in halt and stop.
// - Aux timer keeps its oscillator clock in halt and stop while it selects the oscillator and no stop is requested.
`timescale 1ns/1ps
`include "obwc_defs.vh"
module obwc_loader (
  input  wire        clock,
  input  wire        sys_rst,
  // Flash read port
  output reg  [15:0] flash_addr,
  output reg         flash_rd,
  input  wire [7:0]  flash_rdata,
  input  wire        boot_swap,
  // Power mode and activity pins
  input  wire        halt_mode,
  input  wire        stop_mode,
  input  wire        self_prog_busy,
  input  wire        aux_timer_sel_lsosc,
  // APB
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Decoded outputs
  output reg         cfg_valid,
  output reg  [1:0]  window_open_sel,
  output reg  [4:0]  wdt_overflow_exp,
  output reg         wdt_count_enable,
  output reg         wdt_clk_gate_en,
  output reg         lowspeed_osc_run,
  output reg         aux_timer_clk_en
);
  // ==========================================
  // Loader states
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_READ = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg [3:0] state_r;
  reg [1:0] wait_r;
  reg [7:0] cfg_r;
  reg       swap_m_r, swap_r;
  reg [3:0] halt_m_r, mode_r;
  reg       lsosc_stop_r;
  reg       wdt_started_r;

  wire [1:0] dec_win;
  wire [6:0] dec_pct;
  wire       dec_run;
  wire [2:0] dec_ovf;
  wire [4:0] dec_exp;
  wire       dec_lock;
  wire       dec_illegal;

  obwc_decode u_dec (
    .cfg_byte          (cfg_r),
    .window_open_sel   (dec_win),
    .window_open_pct   (dec_pct),
    .wdt_run_at_reset  (dec_run),
    .wdt_overflow_sel  (dec_ovf),
    .wdt_overflow_exp  (dec_exp),
    .lowspeed_osc_lock (dec_lock),
    .cfg_illegal       (dec_illegal)
  );

  // ==========================================
  // Pin synchronisers
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      swap_m_r <= 1'b0;
      swap_r   <= 1'b0;
      halt_m_r <= 4'h0;
      mode_r   <= 4'h0;
    end else begin
      swap_m_r <= boot_swap;
      swap_r   <= swap_m_r;
      halt_m_r <= {aux_timer_sel_lsosc, self_prog_busy, stop_mode, halt_mode};
      mode_r   <= halt_m_r;
    end
  end

  wire low_power = mode_r[0] | mode_r[1];

  // ==========================================
  // One-shot load after reset release
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= ST_IDLE;
      wait_r     <= 2'h0;
      cfg_r      <= 8'h00;
      cfg_valid  <= 1'b0;
      flash_addr <= 16'h0000;
      flash_rd   <= 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          // Two cycles, so the swap synchroniser held in reset has settled
          if (wait_r == 2'h1) begin
            wait_r  <= 2'h0;
            state_r <= ST_READ;
          end else begin
            wait_r <= wait_r + 2'h1;
          end
        end
        ST_READ: begin
          flash_addr <= swap_r ? `OBWC_ADDR_SWAP : `OBWC_ADDR_PRIMARY;
          flash_rd   <= 1'b1;
          wait_r     <= `OBWC_FLASH_WAIT;
          state_r    <= ST_WAIT;
        end
        ST_WAIT: begin
          flash_rd <= 1'b0;
          if (wait_r == 2'h0) begin
            cfg_r     <= flash_rdata;
            cfg_valid <= 1'b1;
            state_r   <= ST_DONE;
          end else begin
            wait_r <= wait_r - 2'h1;
          end
        end
        ST_DONE: begin
          // Held until next reset
          state_r <= ST_DONE;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ==========================================
  // Software stop request and watchdog start
  wire        acc    = psel & penable;
  wire        wr_hit = acc & pwrite & (paddr == `OBWC_REG_CTRL);

  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      lsosc_stop_r  <= 1'b0;
      wdt_started_r <= 1'b0;
    end else begin
      if (wr_hit) begin
        lsosc_stop_r <= pwdata[0];
        if (pwdata[1])
          wdt_started_r <= 1'b1;
      end
      if (cfg_valid && dec_run)
        wdt_started_r <= 1'b1;
    end
  end

  // ==========================================
  // Decoded outputs, all registered
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      window_open_sel  <= 2'h0;
      wdt_overflow_exp <= 5'h0;
      wdt_count_enable <= 1'b0;
      wdt_clk_gate_en  <= 1'b0;
      lowspeed_osc_run <= 1'b1;
      aux_timer_clk_en <= 1'b0;
    end else begin
      window_open_sel  <= dec_win;
      wdt_overflow_exp <= dec_exp;
      // Self-programming does not pause counting
      wdt_count_enable <= cfg_valid & wdt_started_r;
      wdt_clk_gate_en  <= cfg_valid & ~(low_power & ~dec_lock);
      lowspeed_osc_run <= dec_lock | ~lsosc_stop_r;
      aux_timer_clk_en <= mode_r[3] & ~lsosc_stop_r;
    end
  end

  // ==========================================
  // APB slave, zero wait states
  always @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
      if (psel & ~penable) begin
        case (paddr)
          `OBWC_REG_CFG: begin
            prdata  <= {24'h0, cfg_r};
            pslverr <= pwrite;
          end
          `OBWC_REG_CTRL: prdata <= {30'h0, wdt_started_r, lsosc_stop_r};
          `OBWC_REG_STAT: prdata <= {21'h0, dec_pct, mode_r[2], dec_illegal,
                                     lowspeed_osc_run, cfg_valid};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule

//--- tb_top.sv
// Self-checking bench for the configuration byte loader.
// Assumes the flash model and checker files are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic        clock = 0, sys_rst = 1, boot_swap = 0, halt_mode = 0, stop_mode = 0;
  logic        self_prog_busy = 0, aux_timer_sel_lsosc = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [7:0]  cfg_byte = 0, b;
  logic [33:0] exp_q[$], e;
  wire [31:0]  prdata;
  wire [15:0]  flash_addr;
  wire [7:0]   flash_rdata;
  wire [1:0]   window_open_sel;
  wire [4:0]   wdt_overflow_exp;
  wire         flash_rd, pready, pslverr, cfg_valid, wdt_count_enable;
  wire         wdt_clk_gate_en, lowspeed_osc_run, aux_timer_clk_en;
  int          err_total = 0, checks_done = 0, seed = 32'hba7e, n;
  obwc_loader u_obwc_loader (
    .clock               (clock),
    .sys_rst             (sys_rst),
    .flash_addr          (flash_addr),
    .flash_rd            (flash_rd),
    .flash_rdata         (flash_rdata),
    .boot_swap           (boot_swap),
    .halt_mode           (halt_mode),
    .stop_mode           (stop_mode),
    .self_prog_busy      (self_prog_busy),
    .aux_timer_sel_lsosc (aux_timer_sel_lsosc),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .cfg_valid           (cfg_valid),
    .window_open_sel     (window_open_sel),
    .wdt_overflow_exp    (wdt_overflow_exp),
    .wdt_count_enable    (wdt_count_enable),
    .wdt_clk_gate_en     (wdt_clk_gate_en),
    .lowspeed_osc_run    (lowspeed_osc_run),
    .aux_timer_clk_en    (aux_timer_clk_en)
  );
  obwc_flash_model u_obwc_flash_model (
    .clock       (clock),
    .flash_addr  (flash_addr),
    .flash_rd    (flash_rd),
    .cfg_byte    (cfg_byte),
    .flash_rdata (flash_rdata)
  );
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks_done++;
    if (s !== x) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask
  task tally_and_finish;
    if (err_total == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Entry: bit33 read data checked, bit32 error expected
  task automatic apb(input [11:0] a, input w, input [31:0] d, input [33:0] x);
    int k;
    exp_q.push_back(x);
    @(posedge clock);
    {psel, penable, paddr, pwrite, pwdata} <= {2'h2, a, w, d};
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1 && k < 20);
    if (pready !== 1) begin
      err_total++;
      tally_and_finish;
    end
    {psel, penable} <= 2'h0;
  endtask
  always @(posedge clock)
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      chk(32'(pslverr), 32'(e[32]));
      if (e[33]) chk(prdata, e[31:0]);
    end
  // ==========================================
  // Stimulus
  initial forever #25 clock = ~clock;
  initial begin #2000000; err_total++; tally_and_finish; end
  initial begin
    for (int i = 0; i < 8; i++) begin
      b = 8'($random(seed));
      b[7] = 0;
      b[3:1] = i[2:0];
      if (i == 0) b[6:5] = 2'h1;
      @(posedge clock);
      {cfg_byte, boot_swap, halt_mode, stop_mode, self_prog_busy, sys_rst} <= {b, i[1], 4'h1};
      aux_timer_sel_lsosc <= 1'($random(seed));
      repeat (3) @(posedge clock);
      sys_rst <= 0;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (cfg_valid !== 1 && n < 50);
      if (cfg_valid !== 1) begin
        err_total++;
        tally_and_finish;
      end
      repeat (2) @(posedge clock);
      chk(32'(flash_addr), i[1] ? 32'h1080 : 32'h0080);
      chk(32'(window_open_sel), 32'(b[6:5]));
      chk(32'(wdt_overflow_exp), 32'(b[3:1]) + 32'hA);
      chk(32'(wdt_count_enable), 32'(b[4]));
      cfg_byte <= ~b;
      apb(12'h080, 1, 32'h0, {2'h1, 32'h0});
      apb(12'h080, 0, 32'h0, {2'h2, 24'h0, b});
      apb(12'h00C, 0, 32'h0, {2'h1, 32'h0});
      apb(12'h008, 0, 32'h0,
          {2'h2, 21'h0, 7'(({5'h0, b[6:5]} + 7'h1) * 7'h19), 4'h3});
      {halt_mode, stop_mode} <= {i[0], !i[0]};
      repeat (4) @(posedge clock);
      chk(32'(wdt_clk_gate_en), 32'(b[0]));
      chk(32'(aux_timer_clk_en), 32'(aux_timer_sel_lsosc));
      self_prog_busy <= 1;
      apb(12'h004, 1, 32'h3, 34'h0);
      repeat (2) @(posedge clock);
      chk(32'(lowspeed_osc_run), 32'(b[0]));
      chk(32'(aux_timer_clk_en), 32'h0);
      chk(32'(wdt_count_enable), 32'h1);
      apb(12'h004, 1, 32'h2, 34'h0);
      repeat (2) @(posedge clock);
      chk(32'(lowspeed_osc_run), 32'h1);
    end
    tally_and_finish;
  end
endmodule
bind obwc_loader obwc_checker u_obwc_checker (
  .clock            (clock),
  .sys_rst          (sys_rst),
  .flash_addr       (flash_addr),
  .flash_rd         (flash_rd),
  .psel             (psel),
  .penable          (penable),
  .pready           (pready),
  .pwrite           (pwrite),
  .paddr            (paddr),
  .pwdata           (pwdata),
  .prdata           (prdata),
  .self_prog_busy   (self_prog_busy),
  .cfg_valid        (cfg_valid),
  .window_open_sel  (window_open_sel),
  .wdt_overflow_exp (wdt_overflow_exp),
  .wdt_count_enable (wdt_count_enable),
  .lowspeed_osc_run (lowspeed_osc_run),
  .aux_timer_clk_en (aux_timer_clk_en)
);
